/* inc/isa_pkg.sv */
// shared constants and types for the s-link activation and d-channel block
package isa_pkg;
  // ==========================================================
  // register byte offsets
  localparam logic [7:0] ADDR_CTRL = 8'h00;
  localparam logic [7:0] ADDR_STATUS = 8'h04;
  localparam logic [7:0] ADDR_TX_BASE = 8'h08;
  localparam logic [7:0] ADDR_RX_BASE = 8'h18;
  // ==========================================================
  // control register fields
  localparam int CTL_AR = 0;
  localparam int CTL_DR = 1;
  localparam int CTL_TIMING = 2;
  localparam int CTL_CLASS_HI = 3;
  localparam int CTL_LINE_CFG = 4;
  localparam int CTL_SLAVE = 5;
  localparam int CTL_W = 6;
  localparam logic [5:0] CTRL_RST = 6'h00;
  // ==========================================================
  // status register fields
  localparam int STS_STATE = 0;
  localparam int STS_NT = 3;
  localparam int STS_SLAVE = 4;
  localparam int STS_ADAPT = 5;
  localparam int STS_SETTLED = 6;
  localparam int STS_LVL_LOW = 7;
  localparam int STS_ACK = 8;
  localparam int STS_COLL = 9;
  localparam int STS_BUSY = 10;
  // ==========================================================
  // channels of the frame
  localparam int CH_D = 0;
  localparam int CH_C = 3;
  localparam int NUM_CH = 4;
  // ==========================================================
  // line signal codes, seen on receive and driven on transmit
  localparam logic [2:0] INFO0 = 3'h0;
  localparam logic [2:0] INFO1 = 3'h1;
  localparam logic [2:0] INFO2 = 3'h2;
  localparam logic [2:0] INFO3 = 3'h3;
  localparam logic [2:0] INFO4 = 3'h4;
  // ==========================================================
  // priority terminal counts
  localparam logic [3:0] TERM_HI_A = 4'h8;
  localparam logic [3:0] TERM_HI_B = 4'h9;
  localparam logic [3:0] TERM_LO_A = 4'hA;
  localparam logic [3:0] TERM_LO_B = 4'hB;
  localparam logic [3:0] CNT_MAX = 4'hF;
  // ==========================================================
  // timing
  localparam int CLK_HZ = 25000000;
  localparam int SETTLE_MS = 100;
  localparam int SETTLE_CYC = (CLK_HZ / 1000) * SETTLE_MS;
  localparam int SETTLE_W = 22;
  // ==========================================================
  // activation states
  typedef enum logic [2:0] {
    ISA_IDLE = 3'b000,
    ISA_TE_REQ = 3'b001,
    ISA_TE_ACT = 3'b010,
    ISA_NT_SYNC = 3'b011,
    ISA_NT_ACT = 3'b100
  } isa_state_t;
endpackage

/* hw/isa_bitser.sv */
// one channel serialiser and deserialiser with selectable bit order
`timescale 1ns/10ps
`default_nettype none
module isa_bitser #(
  parameter bit LSB_FIRST = 1'b1
) (
  input wire logic sys_clk_in,
  input wire logic rst_b_in,
  input wire logic ce_in,
  input wire logic load_in,
  input wire logic [7:0] tx_byte_in,
  input wire logic bit_strobe_in,
  input wire logic rx_bit_in,
  output logic tx_bit_out,
  output logic [7:0] rx_byte_out
);
  typedef struct packed {
    logic [7:0] sh;
    logic [7:0] rx;
    logic [7:0] rxb;
    logic txb;
  } isa_ser_t;
  isa_ser_t r, n;

  // ==========================================================
  // shift logic: load at frame start wins over a bit strobe
  always_comb
  begin
    n = r;
    if (load_in)
    begin
      n.sh = tx_byte_in;
      n.rxb = r.rx;
    end
    else if (bit_strobe_in)
    begin
      if (LSB_FIRST)
      begin
        n.txb = r.sh[0];
        n.sh = {1'b0, r.sh[7:1]};
        n.rx = {rx_bit_in, r.rx[7:1]};
      end
      else
      begin
        n.txb = r.sh[7];
        n.sh = {r.sh[6:0], 1'b0};
        n.rx = {r.rx[6:0], rx_bit_in};
      end
    end
  end

  // state register
  always_ff @(posedge sys_clk_in or negedge rst_b_in)
  begin
    if (!rst_b_in)
      r <= '0;
    else if (ce_in)
      r <= n;
  end

  assign tx_bit_out = r.txb;
  assign rx_byte_out = r.rxb;
endmodule
`default_nettype wire

/* hw/isa_link_ctrl.sv */
// s-link activation, d-channel contention and channel ports over ahb-lite
// Function
// - host bytes toward serial ports other than the control channel go out bit zero first
// - host reads channel bytes, control channel aside, with earliest received bit at bit zero
// - backplane d-channel is ordered least significant bit first
// - control channel is ordered most significant bit first
// - deactivated line carries no signal from either end
// - terminal asking for activation sends the info1 pattern
// - network end answers info1 with info2, zero data and a-bit
// - terminal synchronised to info2 answers with info3 live data
// - network end synchronised to info3 sends data with a-bit one
// - network end starting activation sends info2 directly
// - either end deactivates by returning the line to info0
// - echo one increments priority counter, echo zero clears it
// - class picks 8/9 or 10/11, level picks within class
// - at terminal count the terminal seizes the d-channel at once
// - collision stops sending, flags, drops ack, restarts, flushes
// - successful send lowers internal level to larger count
// - lowered level returns high only after its larger count
// - nt slave acts as network end with terminal frame layout
// - network end starts in fixed timing after any reset
// - clearing the timing bit returns to fixed timing
// - network end copies received d bits into the echo bit
//
// Decided for this implementation: the AHB-Lite slave port and the register offsets.
`timescale 1ns/10ps
`default_nettype none
module isa_link_ctrl #(
  parameter int SETTLE_CYCLES = isa_pkg::SETTLE_CYC
) (
  input wire logic sys_clk_in,
  input wire logic rst_b_in,
  input wire logic ce_in,
  input wire logic hsel_in,
  input wire logic [31:0] haddr_in,
  input wire logic [1:0] htrans_in,
  input wire logic hwrite_in,
  input wire logic [2:0] hsize_in,
  input wire logic [31:0] hwdata_in,
  input wire logic hready_in,
  output logic [31:0] hrdata_out,
  output logic hreadyout_out,
  output logic hresp_out,
  input wire logic nt_select_strap_in,
  input wire logic [2:0] rx_info_in,
  output logic [2:0] tx_info_out,
  output logic a_bit_out,
  input wire logic frame_pulse_in,
  input wire logic [3:0] ch_strobe_in,
  input wire logic [3:0] ch_rx_bit_in,
  output logic [3:0] ch_tx_bit_out,
  input wire logic echo_valid_in,
  input wire logic echo_bit_in,
  input wire logic rx_d_valid_in,
  input wire logic rx_d_bit_in,
  output logic tx_echo_bit_out,
  input wire logic tx_pending_in,
  input wire logic tx_done_in,
  input wire logic collision_in,
  output logic dch_seize_out,
  output logic fifo_discard_out,
  output logic dch_access_ack_out,
  output logic adaptive_timing_out,
  output logic line_config_out,
  output logic te_frame_out
);
  typedef struct packed {
    logic s1;
    logic s2;
    logic [1:0] strap_cnt;
    logic nt;
    isa_pkg::isa_state_t st;
    logic [2:0] info;
    logic abit;
    logic data_on;
    logic [5:0] ctl;
    logic [3:0][7:0] txb;
    logic [3:0] cnt;
    logic lvl_low;
    logic busy;
    logic ack;
    logic ack_clr;
    logic coll;
    logic seize;
    logic discard;
    logic echo;
    logic [21:0] settle;
    logic settled;
    logic wr_pend;
    logic rd_wait;
    logic [7:0] addr;
    logic [31:0] rdata;
  } isa_main_t;
  isa_main_t r, n;
  logic [3:0][7:0] rx_byte;
  logic [3:0] term;
  logic te_act;
  logic [31:0] rd_word;

  // ==========================================================
  // channel serialisers, data bytes zero outside data states
  genvar gi;
  generate
    for (gi = 0; gi < isa_pkg::NUM_CH; gi++)
    begin : g_ch
      isa_bitser #(
        .LSB_FIRST(gi != isa_pkg::CH_C)
      ) u_ser (
        .sys_clk_in(sys_clk_in),
        .rst_b_in(rst_b_in),
        .ce_in(ce_in),
        .load_in(frame_pulse_in),
        .tx_byte_in((r.data_on || gi == isa_pkg::CH_C) ?
                    r.txb[gi] : 8'h00),
        .bit_strobe_in(ch_strobe_in[gi]),
        .rx_bit_in(ch_rx_bit_in[gi]),
        .tx_bit_out(ch_tx_bit_out[gi]),
        .rx_byte_out(rx_byte[gi])
      );
    end
  endgenerate
  // ==========================================================
  // terminal count selection, class above level
  always_comb
  begin
    if (r.ctl[isa_pkg::CTL_CLASS_HI])
      term = r.lvl_low ? isa_pkg::TERM_HI_B : isa_pkg::TERM_HI_A;
    else
      term = r.lvl_low ? isa_pkg::TERM_LO_B : isa_pkg::TERM_LO_A;
  end

  assign te_act = (r.st == isa_pkg::ISA_TE_ACT) && !r.nt;

  // read mux for the register bus
  always_comb
  begin
    rd_word = 32'h0000_0000;
    if (r.addr == isa_pkg::ADDR_CTRL)
      rd_word[5:0] = r.ctl;
    if (r.addr == isa_pkg::ADDR_STATUS)
    begin
      rd_word[2:0] = r.st;
      rd_word[isa_pkg::STS_NT] = r.nt;
      rd_word[isa_pkg::STS_SLAVE] = r.ctl[isa_pkg::CTL_SLAVE];
      rd_word[isa_pkg::STS_ADAPT] = adaptive_timing_out;
      rd_word[isa_pkg::STS_SETTLED] = r.settled;
      rd_word[isa_pkg::STS_LVL_LOW] = r.lvl_low;
      rd_word[isa_pkg::STS_ACK] = r.ack;
      rd_word[isa_pkg::STS_COLL] = r.coll;
      rd_word[isa_pkg::STS_BUSY] = r.busy;
    end
    for (int i = 0; i < isa_pkg::NUM_CH; i++)
    begin
      if (r.addr == isa_pkg::ADDR_TX_BASE + 8'(4 * i))
        rd_word[7:0] = r.txb[i];
      if (r.addr == isa_pkg::ADDR_RX_BASE + 8'(4 * i))
        rd_word[7:0] = rx_byte[i];
    end
  end
  // ==========================================================
  // next-state logic of the whole block
  always_comb
  begin
    n = r;
    n.seize = 1'b0;
    n.discard = 1'b0;
    // strap sampled through two flops, latched once after release
    n.s1 = nt_select_strap_in;
    n.s2 = r.s1;
    if (r.strap_cnt != 2'h3)
    begin
      n.strap_cnt = r.strap_cnt + 2'h1;
      if (r.strap_cnt == 2'h2)
        n.nt = r.s2;
    end
    // bus address phase and write data phase
    n.wr_pend = 1'b0;
    n.rd_wait = 1'b0;
    if (hsel_in && htrans_in[1] && hready_in)
    begin
      n.addr = haddr_in[7:0];
      n.wr_pend = hwrite_in;
      n.rd_wait = !hwrite_in;
    end
    if (r.rd_wait)
      n.rdata = rd_word;
    if (r.wr_pend)
    begin
      if (r.addr == isa_pkg::ADDR_CTRL)
        n.ctl = hwdata_in[5:0];
      if (r.addr == isa_pkg::ADDR_STATUS && hwdata_in[isa_pkg::STS_COLL])
        n.coll = 1'b0;
      for (int i = 0; i < isa_pkg::NUM_CH; i++)
        if (r.addr == isa_pkg::ADDR_TX_BASE + 8'(4 * i))
          n.txb[i] = hwdata_in[7:0];
    end
    // activation state machine
    case (r.st)
      isa_pkg::ISA_IDLE:
      begin
        if (r.nt)
        begin
          if (r.ctl[isa_pkg::CTL_AR] || rx_info_in == isa_pkg::INFO1)
            n.st = isa_pkg::ISA_NT_SYNC;
        end
        else if (rx_info_in == isa_pkg::INFO2 ||
                 rx_info_in == isa_pkg::INFO4)
          n.st = isa_pkg::ISA_TE_ACT;
        else if (r.ctl[isa_pkg::CTL_AR])
          n.st = isa_pkg::ISA_TE_REQ;
      end
      isa_pkg::ISA_TE_REQ:
        if (rx_info_in == isa_pkg::INFO2 || rx_info_in == isa_pkg::INFO4)
          n.st = isa_pkg::ISA_TE_ACT;
      isa_pkg::ISA_TE_ACT:
        if (rx_info_in == isa_pkg::INFO0)
          n.st = isa_pkg::ISA_IDLE;
      isa_pkg::ISA_NT_SYNC:
        if (rx_info_in == isa_pkg::INFO3)
          n.st = isa_pkg::ISA_NT_ACT;
      isa_pkg::ISA_NT_ACT:
        if (rx_info_in == isa_pkg::INFO0)
          n.st = isa_pkg::ISA_IDLE;
      default:
        n.st = isa_pkg::ISA_IDLE;
    endcase
    if (r.ctl[isa_pkg::CTL_DR])
      n.st = isa_pkg::ISA_IDLE;
    // line signal driven from the next state
    case (n.st)
      isa_pkg::ISA_TE_REQ: n.info = isa_pkg::INFO1;
      isa_pkg::ISA_TE_ACT: n.info = isa_pkg::INFO3;
      isa_pkg::ISA_NT_SYNC: n.info = isa_pkg::INFO2;
      isa_pkg::ISA_NT_ACT: n.info = isa_pkg::INFO4;
      default: n.info = isa_pkg::INFO0;
    endcase
    n.abit = (n.st == isa_pkg::ISA_NT_ACT);
    n.data_on = (n.st == isa_pkg::ISA_TE_ACT) ||
                (n.st == isa_pkg::ISA_NT_ACT);
    // echo of received d bits on the network end
    if (r.nt && rx_d_valid_in)
      n.echo = rx_d_bit_in;
    // priority counter on the echo stream
    if (echo_valid_in)
    begin
      if (!echo_bit_in)
        n.cnt = 4'h0;
      else if (r.cnt != isa_pkg::CNT_MAX)
        n.cnt = r.cnt + 4'h1;
    end
    if (r.lvl_low && r.cnt >= term && !r.busy)
      n.lvl_low = 1'b0;
    // ack drop before seize, so a grant in the same cycle wins
    if (r.ack_clr && frame_pulse_in)
    begin
      n.ack = 1'b0;
      n.ack_clr = 1'b0;
    end
    if (te_act && !r.busy && tx_pending_in && r.cnt >= term)
    begin
      n.seize = 1'b1;
      n.busy = 1'b1;
      n.ack = 1'b1;
      n.ack_clr = 1'b0; // stale drop must not hit the new grant
    end
    if (r.busy && tx_done_in)
    begin
      n.busy = 1'b0;
      n.lvl_low = 1'b1;
    end
    if (r.busy && collision_in)
    begin
      n.busy = 1'b0;
      n.coll = 1'b1;
      n.discard = 1'b1;
      n.cnt = 4'h0;
      n.ack_clr = 1'b1;
    end
    // settling time after entering adaptive timing
    if (!adaptive_timing_out)
    begin
      n.settle = 22'h00_0000;
      n.settled = 1'b0;
    end
    else if (r.settle != 22'(SETTLE_CYCLES - 1))
      n.settle = r.settle + 22'h00_0001;
    else
      n.settled = 1'b1;
  end
  // state register
  always_ff @(posedge sys_clk_in or negedge rst_b_in)
  begin
    if (!rst_b_in)
      r <= '0;
    else if (ce_in)
      r <= n;
  end
  // ==========================================================
  // outputs
  assign hrdata_out = r.rdata;
  assign hreadyout_out = !r.rd_wait;
  assign hresp_out = 1'b0;
  assign tx_info_out = r.info;
  assign a_bit_out = r.abit;
  assign tx_echo_bit_out = r.echo;
  assign dch_seize_out = r.seize;
  assign fifo_discard_out = r.discard;
  assign dch_access_ack_out = r.ack;
  assign adaptive_timing_out = r.nt && r.ctl[isa_pkg::CTL_TIMING];
  assign line_config_out = r.ctl[isa_pkg::CTL_LINE_CFG];
  assign te_frame_out = !r.nt || r.ctl[isa_pkg::CTL_SLAVE];
  // ==========================================================
  // checks
  property p_coll;
    @(posedge sys_clk_in) disable iff (!rst_b_in)
    (ce_in && r.busy && collision_in) |=>
      (!r.busy && r.coll && fifo_discard_out && r.cnt == 4'h0);
  endproperty
  a_coll: assert property (p_coll) else $error("collision not handled");
  property p_seize;
    @(posedge sys_clk_in) disable iff (!rst_b_in)
    (ce_in && te_act && !r.busy && tx_pending_in && r.cnt >= term &&
     !tx_done_in) |=> (dch_seize_out && r.busy && dch_access_ack_out);
  endproperty
  a_seize: assert property (p_seize) else $error("no seize at count");
  property p_echo_zero;
    @(posedge sys_clk_in) disable iff (!rst_b_in)
    (ce_in && echo_valid_in && !echo_bit_in) |=> (r.cnt == 4'h0);
  endproperty
  a_echo_zero: assert property (p_echo_zero) else $error("cnt not clr");
  property p_echo_inc;
    @(posedge sys_clk_in) disable iff (!rst_b_in)
    (ce_in && echo_valid_in && echo_bit_in && r.cnt < 4'hF &&
     !(r.busy && collision_in)) |=> (r.cnt == $past(r.cnt) + 4'h1);
  endproperty
  a_echo_inc: assert property (p_echo_inc) else $error("cnt not inc");
  property p_term_hi;
    @(posedge sys_clk_in) disable iff (!rst_b_in)
    (r.ctl[isa_pkg::CTL_CLASS_HI] && !r.lvl_low) |-> (term == 4'h8);
  endproperty
  a_term_hi: assert property (p_term_hi) else $error("wrong term");
  property p_done_low;
    @(posedge sys_clk_in) disable iff (!rst_b_in)
    (ce_in && r.busy && tx_done_in && !collision_in) |=>
      (r.lvl_low && !r.busy);
  endproperty
  a_done_low: assert property (p_done_low) else $error("level kept");
  property p_nt_info2;
    @(posedge sys_clk_in) disable iff (!rst_b_in)
    (ce_in && r.nt && r.st == isa_pkg::ISA_IDLE && !r.ctl[1] &&
     rx_info_in == isa_pkg::INFO1) |=>
      (tx_info_out == isa_pkg::INFO2 && !a_bit_out);
  endproperty
  a_nt_info2: assert property (p_nt_info2) else $error("no info2");
  property p_nt_act;
    @(posedge sys_clk_in) disable iff (!rst_b_in)
    (ce_in && r.st == isa_pkg::ISA_NT_SYNC && !r.ctl[1] &&
     rx_info_in == isa_pkg::INFO3) |=> (a_bit_out && r.data_on);
  endproperty
  a_nt_act: assert property (p_nt_act) else $error("no a-bit");
  property p_deact;
    @(posedge sys_clk_in) disable iff (!rst_b_in)
    (ce_in && r.ctl[isa_pkg::CTL_DR]) |=>
      (tx_info_out == isa_pkg::INFO0 && !a_bit_out);
  endproperty
  a_deact: assert property (p_deact) else $error("line not idle");
endmodule
`default_nettype wire

/* dv/isa_far_end.sv */
// far-end line partner answering the block's line signal codes
`timescale 1ns/10ps
`default_nettype none
module isa_far_end #(
  parameter int DLY = 8
) (
  input wire logic sys_clk_in,
  input wire logic rst_b_in,
  input wire logic nt_far_in,
  input wire logic req_in,
  input wire logic drop_in,
  input wire logic [2:0] line_tx_in,
  output logic [2:0] line_rx_out
);
  logic [2:0] goal;
  logic [7:0] wait_q;
  // ==========================================================
  // code the far end wants to send
  always_comb
  begin
    if (drop_in)
      goal = isa_pkg::INFO0;
    else if (nt_far_in && line_tx_in == isa_pkg::INFO3)
      goal = isa_pkg::INFO4;
    else if (nt_far_in && (line_tx_in == isa_pkg::INFO1 || req_in))
      goal = isa_pkg::INFO2;
    else if (!nt_far_in && (line_tx_in == isa_pkg::INFO2 ||
             line_tx_in == isa_pkg::INFO4))
      goal = isa_pkg::INFO3;
    else if (!nt_far_in && req_in)
      goal = isa_pkg::INFO1;
    else
      goal = isa_pkg::INFO0;
  end
  // answer only after a delay, so the block sees slow partners
  always_ff @(posedge sys_clk_in or negedge rst_b_in)
  begin
    if (!rst_b_in)
    begin
      line_rx_out <= isa_pkg::INFO0;
      wait_q <= 8'h00;
    end
    else if (goal == line_rx_out)
      wait_q <= 8'h00;
    else if (wait_q == 8'(DLY))
    begin
      line_rx_out <= goal;
      wait_q <= 8'h00;
    end
    else
      wait_q <= wait_q + 8'h01;
  end
endmodule
`default_nettype wire

/* dv/isa_link_ctrl_tb_top.sv */
// self-checking bench for the s-link activation and d-channel block
`timescale 1ns/10ps
`default_nettype none
`define CHK(nm, ex, gt) begin n_tests++; if ((gt) !== (ex)) begin \
  $display("Error %s expected %0h seen %0h", nm, ex, gt); \
  err_count++; end end
module isa_link_ctrl_tb_top;
  logic sys_clk, rst_b, strap, fp, ev, eb, dv, db, pend, done, coll;
  logic hsel, hwrite, hready, far_nt, far_req, far_drop;
  logic [1:0] htrans;
  logic [31:0] haddr, hwdata, hrdata;
  logic [2:0] rx_info, tx_info;
  logic [3:0] stb, rxb, txb;
  logic a_bit, echo_o, seize, disc, ack, adapt, lcfg, tefr, hresp;
  int err_count = 0, n_tests = 0, cyc = 0, seize_n = 0, disc_n = 0;
  // ==========================================================
  // design, partner, clock and watchdog
  isa_link_ctrl #(.SETTLE_CYCLES(16)) u_dut (.sys_clk_in(sys_clk),
    .rst_b_in(rst_b), .ce_in(1'b1), .hsel_in(hsel), .haddr_in(haddr),
    .htrans_in(htrans), .hwrite_in(hwrite), .hsize_in(3'h2),
    .hwdata_in(hwdata), .hready_in(hready), .hrdata_out(hrdata),
    .hreadyout_out(hready), .hresp_out(hresp), .nt_select_strap_in(strap),
    .rx_info_in(rx_info), .tx_info_out(tx_info), .a_bit_out(a_bit),
    .frame_pulse_in(fp), .ch_strobe_in(stb), .ch_rx_bit_in(rxb),
    .ch_tx_bit_out(txb), .echo_valid_in(ev), .echo_bit_in(eb),
    .rx_d_valid_in(dv), .rx_d_bit_in(db), .tx_echo_bit_out(echo_o),
    .tx_pending_in(pend), .tx_done_in(done), .collision_in(coll),
    .dch_seize_out(seize), .fifo_discard_out(disc),
    .dch_access_ack_out(ack), .adaptive_timing_out(adapt),
    .line_config_out(lcfg), .te_frame_out(tefr));
  isa_far_end #(.DLY(8)) u_far (.sys_clk_in(sys_clk), .rst_b_in(rst_b),
    .nt_far_in(far_nt), .req_in(far_req), .drop_in(far_drop),
    .line_tx_in(tx_info), .line_rx_out(rx_info));
  initial
  begin
    sys_clk = 1'b0;
    forever #20 sys_clk = ~sys_clk;
  end
  // count pulses and cut a hang short
  always @(posedge sys_clk)
  begin
    cyc++;
    seize_n += (seize === 1'b1);
    disc_n += (disc === 1'b1);
    if (cyc == 20000)
    begin
      err_count++;
      tally_and_finish();
    end
  end
  // ==========================================================
  // shared tasks
  task automatic tally_and_finish;
    if (err_count == 0 && n_tests > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge sys_clk);
    #1;
  endtask
  task automatic ahb(input logic w, input logic [7:0] a,
    input logic [31:0] wd, output logic [31:0] rd);
    @(posedge sys_clk);
    hsel <= 1'b1; htrans <= 2'h2; haddr <= {24'h0, a}; hwrite <= w;
    do @(posedge sys_clk); while (hready !== 1'b1);
    hsel <= 1'b0; htrans <= 2'h0; hwdata <= wd;
    do @(posedge sys_clk); while (hready !== 1'b1);
    rd = hrdata;
  endtask
  task automatic wait_info(input logic [2:0] code);
    for (int i = 0; i < 60 && tx_info !== code; i++) tick(1);
    `CHK("tx_info", code, tx_info)
  endtask
  task automatic fpulse;
    @(posedge sys_clk) fp <= 1'b1;
    @(posedge sys_clk) fp <= 1'b0;
  endtask
  task automatic echo(input int n, input logic b);
    @(posedge sys_clk) {ev, eb} <= {1'b1, b};
    repeat (n) @(posedge sys_clk);
    ev <= 1'b0;
    tick(3);
  endtask
  task automatic do_reset(input logic s);
    @(posedge sys_clk) {rst_b, strap, far_nt} <= {1'b0, s, ~s};
    repeat (10) @(posedge sys_clk);
    rst_b <= 1'b1;
    tick(5);
  endtask
  task automatic chan(input int ch, input logic [7:0] off,
    input logic [7:0] v);
    logic [31:0] rd;
    logic [7:0] got;
    int k;
    ahb(1'b1, off, {24'h0, v}, rd);
    fpulse();
    for (int i = 0; i < 8; i++)
    begin
      k = (ch == isa_pkg::CH_C) ? 7 - i : i;
      @(posedge sys_clk) {stb, rxb} <= {4'(1 << ch), {4{v[k]}}};
      @(posedge sys_clk) stb <= 4'h0;
      #1 got[k] = txb[ch];
    end
    fpulse();
    ahb(1'b0, off + 8'h10, 32'h0, rd);
    `CHK("tx byte", v, got)
    `CHK("rx byte", {24'h0, v}, rd)
  endtask
  // ==========================================================
  // scenarios
  task automatic t_te_up;
    logic [31:0] rd;
    ahb(1'b0, 8'h40, 32'h0, rd);
    `CHK("unmapped", 32'h0, rd)
    `CHK("hresp", 1'b0, hresp)
    wait_info(isa_pkg::INFO0);
    ahb(1'b1, isa_pkg::ADDR_CTRL, 32'h01, rd);
    wait_info(isa_pkg::INFO1);
    wait_info(isa_pkg::INFO3);
    `CHK("te frame", 1'b1, tefr)
  endtask
  task automatic t_prio;
    logic [31:0] rd;
    ahb(1'b1, isa_pkg::ADDR_CTRL, 32'h09, rd);
    @(posedge sys_clk) pend <= 1'b1;
    echo(7, 1'b1);
    `CHK("seize", 0, seize_n)
    echo(1, 1'b1);
    `CHK("seize", 1, seize_n)
    `CHK("ack", 1'b1, ack)
    @(posedge sys_clk) done <= 1'b1;
    @(posedge sys_clk) done <= 1'b0;
    ahb(1'b0, isa_pkg::ADDR_STATUS, 32'h0, rd);
    `CHK("level low", 1'b1, rd[7])
    echo(1, 1'b0);
    echo(5, 1'b1);
    echo(1, 1'b0);
    echo(8, 1'b1);
    `CHK("seize", 1, seize_n)
    echo(1, 1'b1);
    `CHK("seize", 2, seize_n)
    @(posedge sys_clk) coll <= 1'b1;
    @(posedge sys_clk) coll <= 1'b0;
    tick(2);
    `CHK("discard", 1, disc_n)
    `CHK("ack held", 1'b1, ack)
    ahb(1'b0, isa_pkg::ADDR_STATUS, 32'h0, rd);
    `CHK("coll busy", 2'h1, rd[10:9])
    fpulse();
    tick(1);
    `CHK("ack", 1'b0, ack)
    ahb(1'b1, isa_pkg::ADDR_CTRL, 32'h01, rd);
    @(posedge sys_clk) pend <= 1'b0;
    echo(11, 1'b1);
    ahb(1'b0, isa_pkg::ADDR_STATUS, 32'h0, rd);
    `CHK("level low", 1'b0, rd[7])
    echo(1, 1'b0);
    @(posedge sys_clk) pend <= 1'b1;
    echo(9, 1'b1);
    `CHK("seize", 2, seize_n)
    echo(1, 1'b1);
    `CHK("seize", 3, seize_n)
    @(posedge sys_clk) {pend, done} <= 2'b01;
    @(posedge sys_clk) done <= 1'b0;
  endtask
  task automatic t_te_down;
    logic [31:0] rd;
    ahb(1'b1, isa_pkg::ADDR_CTRL, 32'h00, rd);
    @(posedge sys_clk) far_drop <= 1'b1;
    wait_info(isa_pkg::INFO0);
    @(posedge sys_clk) far_drop <= 1'b0;
  endtask
  task automatic t_nt_link;
    logic [31:0] rd;
    ahb(1'b0, isa_pkg::ADDR_STATUS, 32'h0, rd);
    `CHK("nt fixed", 2'h1, {rd[5], rd[3]})
    `CHK("te frame", 1'b0, tefr)
    @(posedge sys_clk) far_req <= 1'b1;
    wait_info(isa_pkg::INFO2);
    `CHK("a bit", 1'b0, a_bit)
    wait_info(isa_pkg::INFO4);
    `CHK("a bit", 1'b1, a_bit)
    for (int i = 0; i < 2; i++)
    begin
      @(posedge sys_clk) {dv, db} <= {1'b1, ~1'(i)};
      @(posedge sys_clk) dv <= 1'b0;
      tick(1);
      `CHK("echo", ~1'(i), echo_o)
    end
    @(posedge sys_clk) {far_req, far_drop} <= 2'b01;
    wait_info(isa_pkg::INFO0);
    @(posedge sys_clk) far_drop <= 1'b0;
    ahb(1'b1, isa_pkg::ADDR_CTRL, 32'h01, rd);
    wait_info(isa_pkg::INFO2);
    wait_info(isa_pkg::INFO4);
  endtask
  task automatic t_nt_timing;
    logic [31:0] rd;
    ahb(1'b1, isa_pkg::ADDR_CTRL, 32'h06, rd);
    wait_info(isa_pkg::INFO0);
    `CHK("adaptive", 1'b1, adapt)
    tick(20);
    ahb(1'b0, isa_pkg::ADDR_STATUS, 32'h0, rd);
    `CHK("settled", 1'b1, rd[6])
    ahb(1'b1, isa_pkg::ADDR_CTRL, 32'h00, rd);
    tick(1);
    `CHK("adaptive", 1'b0, adapt)
    ahb(1'b1, isa_pkg::ADDR_CTRL, 32'h30, rd);
    tick(1);
    `CHK("line cfg", 1'b1, lcfg)
    `CHK("te frame", 1'b1, tefr)
  endtask
  // ==========================================================
  // main sequence
  initial
  begin
    {rst_b, strap, fp, ev, eb, dv, db, pend, done, coll} = 10'h0;
    {hsel, hwrite, far_nt, far_req, far_drop} = 5'h0;
    {htrans, haddr, hwdata, stb, rxb} = 74'h0;
    do_reset(1'b0);
    t_te_up();
    chan(isa_pkg::CH_D, isa_pkg::ADDR_TX_BASE, 8'hB4);
    chan(1, 8'h0C, 8'h6D);
    chan(2, 8'h10, 8'h5A);
    chan(isa_pkg::CH_C, 8'h14, 8'hB4);
    t_prio();
    t_te_down();
    do_reset(1'b1);
    t_nt_link();
    t_nt_timing();
    tally_and_finish();
  end
endmodule
`default_nettype wire
